//--- logic/pgwm_port.sv
// Top of the eight-pin port: APB registers, pin drive, power-mode hold
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module pgwm_port
  import pgwm_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power mode and LCD field
  input wire pgwm_pkg::pgwm_mode_e powerMode,
  input wire logic [pgwm_pkg::SEGMENT_FIELD_WIDTH-1:0] lcdSegmentSelectField,
  // Pins, output enable low while driving
  input wire logic [WIDTH-1:0] generalIoPinIn,
  output logic [WIDTH-1:0] generalIoPinOut,
  output logic [WIDTH-1:0] generalIoPinOeN,
  output logic [WIDTH-1:0] pullupOn,
  // Wakeup and segment hand-over
  output logic [WIDTH-1:0] wakeupRequestInput,
  output logic [WIDTH-1:0] lcdSegmentOutputEn
);
  import pgwm_pkg::*;

  logic [WIDTH-1:0] portOutputData;
  logic [WIDTH-1:0] portDirection;
  logic [WIDTH-1:0] portPullupEnable;
  logic [WIDTH-1:0] pinFunctionSelect;
  logic [WIDTH-1:0] pinSample;
  logic [WIDTH-1:0] next_drive;
  logic [WIDTH-1:0] next_level;
  logic [WIDTH-1:0] next_pullup;
  logic [WIDTH-1:0] next_wakeEn;
  logic [WIDTH-1:0] next_segmentOwn;
  logic wrStrobe;
  logic rdSetup;
  logic [ADDR_WIDTH-1:0] addr;
  logic mapped;
  logic lowByte;
  logic running;
  logic holding;

  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [ADDR_WIDTH-1:0] r);
    hit = (a == r);
  endfunction : hit

  assign addr = paddr[ADDR_WIDTH-1:0];
  assign mapped = (paddr[31:ADDR_WIDTH] == '0) && (hit(addr, ADDR_FUNC_SEL)
    || hit(addr, ADDR_OUT_DATA) || hit(addr, ADDR_PULLUP) || hit(addr, ADDR_DIRECTION));
  assign wrStrobe = psel && penable && pwrite && pready;
  assign rdSetup = psel && !penable && !pwrite;
  assign lowByte = pstrb[0];
  assign running = (powerMode == PGWM_ACTIVE) || (powerMode == PGWM_SUBACTIVE);
  assign holding = (powerMode == PGWM_SLEEP) || (powerMode == PGWM_SUBSLEEP)
    || (powerMode == PGWM_WATCH);

  // Registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      portOutputData <= RST_OUT_DATA;
      portDirection <= RST_DIRECTION;
      portPullupEnable <= RST_PULLUP;
      pinFunctionSelect <= RST_FUNC_SEL;
    end
    else if (wrStrobe && lowByte)
    begin
      if (hit(addr, ADDR_OUT_DATA))
        portOutputData <= pwdata[WIDTH-1:0];
      if (hit(addr, ADDR_DIRECTION))
        portDirection <= pwdata[WIDTH-1:0];
      if (hit(addr, ADDR_PULLUP))
        portPullupEnable <= pwdata[WIDTH-1:0];
      if (hit(addr, ADDR_FUNC_SEL))
        pinFunctionSelect <= pwdata[WIDTH-1:0];
    end
  end

  // Pin sample register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pinSample <= '0;
    else
      pinSample <= generalIoPinIn;
  end

  // APB answer: one wait-free access phase
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (rdSetup)
      begin
        prdata <= '0;
        if (hit(addr, ADDR_OUT_DATA))
          prdata[WIDTH-1:0] <= (portDirection & portOutputData)
            | (~portDirection & pinSample);
        if (hit(addr, ADDR_DIRECTION))
          prdata[WIDTH-1:0] <= DIRECTION_READ[WIDTH-1:0];
        if (hit(addr, ADDR_PULLUP))
          prdata[WIDTH-1:0] <= portPullupEnable;
        if (hit(addr, ADDR_FUNC_SEL))
          prdata[WIDTH-1:0] <= pinFunctionSelect;
      end
    end
  end

  pgwm_pin_select #(
    .WIDTH(WIDTH)
  ) u_select (
    .direction(portDirection),
    .outData(portOutputData),
    .pullupEn(portPullupEnable),
    .funcSel(pinFunctionSelect),
    .segmentField(lcdSegmentSelectField),
    .next_drive(next_drive),
    .next_level(next_level),
    .next_pullup(next_pullup),
    .next_wakeEn(next_wakeEn),
    .next_segmentOwn(next_segmentOwn)
  );

  // Pin outputs: float in reset/standby, hold in sleep modes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      generalIoPinOut <= '0;
      generalIoPinOeN <= '1;
      pullupOn <= '0;
      wakeupRequestInput <= '0;
      lcdSegmentOutputEn <= '0;
    end
    else if (running)
    begin
      generalIoPinOut <= next_level;
      generalIoPinOeN <= ~next_drive;
      pullupOn <= next_pullup;
      wakeupRequestInput <= next_wakeEn;
      lcdSegmentOutputEn <= next_segmentOwn;
    end
    else if (!holding)
    begin
      generalIoPinOeN <= '1;
      pullupOn <= next_pullup;
    end
  end

  // Assertions
  property p_readback;
    @(posedge clk_sys) disable iff (rst)
    (rdSetup && hit(addr, ADDR_OUT_DATA)) |=> prdata[WIDTH-1:0] ==
      (($past(portDirection) & $past(portOutputData))
      | (~$past(portDirection) & $past(pinSample)));
  endproperty
  a_readback: assert property (p_readback) else $error("port read mismatch");

  property p_dir_ones;
    @(posedge clk_sys) disable iff (rst)
    (rdSetup && hit(addr, ADDR_DIRECTION)) |=> prdata == {24'h000000, DIRECTION_READ};
  endproperty
  a_dir_ones: assert property (p_dir_ones) else $error("direction read not ones");

  property p_pullup_read;
    @(posedge clk_sys) disable iff (rst)
    (rdSetup && hit(addr, ADDR_PULLUP)) |=> prdata[WIDTH-1:0] == $past(portPullupEnable);
  endproperty
  a_pullup_read: assert property (p_pullup_read) else $error("pull-up read bad");

  property p_func_read;
    @(posedge clk_sys) disable iff (rst)
    (rdSetup && hit(addr, ADDR_FUNC_SEL)) |=> prdata[WIDTH-1:0] == $past(pinFunctionSelect);
  endproperty
  a_func_read: assert property (p_func_read) else $error("mode read bad");

  property p_write_data;
    @(posedge clk_sys) disable iff (rst)
    (wrStrobe && lowByte && hit(addr, ADDR_OUT_DATA)) |=> portOutputData == $past(pwdata[WIDTH-1:0]);
  endproperty
  a_write_data: assert property (p_write_data) else $error("data write lost");

  property p_write_dir;
    @(posedge clk_sys) disable iff (rst)
    (wrStrobe && lowByte && hit(addr, ADDR_DIRECTION)) |=> portDirection == $past(pwdata[WIDTH-1:0]);
  endproperty
  a_write_dir: assert property (p_write_dir) else $error("direction write lost");

  property p_write_pullup;
    @(posedge clk_sys) disable iff (rst)
    (wrStrobe && lowByte && hit(addr, ADDR_PULLUP)) |=> portPullupEnable == $past(pwdata[WIDTH-1:0]);
  endproperty
  a_write_pullup: assert property (p_write_pullup) else $error("pull-up write lost");

  property p_write_func;
    @(posedge clk_sys) disable iff (rst)
    (wrStrobe && lowByte && hit(addr, ADDR_FUNC_SEL)) |=> pinFunctionSelect == $past(pwdata[WIDTH-1:0]);
  endproperty
  a_write_func: assert property (p_write_func) else $error("mode write lost");

  property p_strobe_off;
    @(posedge clk_sys) disable iff (rst)
    (wrStrobe && !lowByte) |=> $stable(portOutputData) && $stable(portDirection)
      && $stable(portPullupEnable) && $stable(pinFunctionSelect);
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("masked write landed");

  property p_answer;
    @(posedge clk_sys) disable iff (rst)
    (psel && !penable) |=> pready && (pslverr == !$past(mapped));
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer wrong");

  property p_level;
    @(posedge clk_sys) disable iff (rst)
    running |=> generalIoPinOut == $past(portOutputData);
  endproperty
  a_level: assert property (p_level) else $error("pin level wrong");

  property p_drive;
    @(posedge clk_sys) disable iff (rst)
    running |=> generalIoPinOeN == ~($past(portDirection) & ~$past(pinFunctionSelect)
      & {WIDTH{!$past(lcdSegmentSelectField[SEGMENT_SELECT_BIT])}});
  endproperty
  a_drive: assert property (p_drive) else $error("drive enable wrong");

  property p_pullup;
    @(posedge clk_sys) disable iff (rst)
    running |=> pullupOn == ($past(portPullupEnable) & ~$past(portDirection)
      & ~{WIDTH{$past(lcdSegmentSelectField[SEGMENT_SELECT_BIT])}});
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up wrong");

  property p_wake;
    @(posedge clk_sys) disable iff (rst)
    running |=> (wakeupRequestInput & ~generalIoPinOeN) == '0;
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup pin driving");

  property p_wake_sel;
    @(posedge clk_sys) disable iff (rst)
    running |=> wakeupRequestInput == ($past(pinFunctionSelect)
      & ~{WIDTH{$past(lcdSegmentSelectField[SEGMENT_SELECT_BIT])}});
  endproperty
  a_wake_sel: assert property (p_wake_sel) else $error("wakeup select wrong");

  property p_segment;
    @(posedge clk_sys) disable iff (rst)
    (running && lcdSegmentSelectField[SEGMENT_SELECT_BIT]) |=>
      lcdSegmentOutputEn == '1 && generalIoPinOeN == '1 && wakeupRequestInput == '0;
  endproperty
  a_segment: assert property (p_segment) else $error("segment hand-over wrong");

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
    holding |=> $stable(generalIoPinOeN) && $stable(generalIoPinOut);
  endproperty
  a_hold: assert property (p_hold) else $error("pins not held");

  property p_standby;
    @(posedge clk_sys) disable iff (rst)
    (powerMode == PGWM_STANDBY) |=> generalIoPinOeN == '1;
  endproperty
  a_standby: assert property (p_standby) else $error("pin driven in standby");

  property p_reset_float;
    @(posedge clk_sys)
    rst |-> generalIoPinOeN == '1 && pullupOn == '0 && wakeupRequestInput == '0;
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("pins active in reset");

  property p_reset_regs;
    @(posedge clk_sys)
    rst |-> portOutputData == RST_OUT_DATA && portDirection == RST_DIRECTION
      && portPullupEnable == RST_PULLUP && pinFunctionSelect == RST_FUNC_SEL;
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("registers not cleared");

  c_write: cover property (@(posedge clk_sys) disable iff (rst) wrStrobe);
  c_drive: cover property (@(posedge clk_sys) disable iff (rst) generalIoPinOeN != '1);
  c_wake: cover property (@(posedge clk_sys) disable iff (rst) wakeupRequestInput != '0);
  c_segment: cover property (@(posedge clk_sys) disable iff (rst) lcdSegmentOutputEn == '1);
  c_hold: cover property (@(posedge clk_sys) disable iff (rst) holding);
endmodule : pgwm_port

//--- logic/pgwm_pkg.sv
// Package of constants for the eight-pin port with wakeup and segment sharing
package pgwm_pkg;
  localparam int PORT_WIDTH = 8;
  localparam int SEGMENT_FIELD_WIDTH = 4;
  localparam int ADDR_WIDTH = 16;
  localparam logic [ADDR_WIDTH-1:0] ADDR_FUNC_SEL = 16'hffcc;
  localparam logic [ADDR_WIDTH-1:0] ADDR_OUT_DATA = 16'hffd8;
  localparam logic [ADDR_WIDTH-1:0] ADDR_PULLUP = 16'hffe2;
  localparam logic [ADDR_WIDTH-1:0] ADDR_DIRECTION = 16'hffe8;
  localparam logic [7:0] RST_FUNC_SEL = 8'h00;
  localparam logic [7:0] RST_OUT_DATA = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] DIRECTION_READ = 8'hff;
  localparam int SEGMENT_SELECT_BIT = 3;
  typedef enum logic [2:0] {
    PGWM_ACTIVE,
    PGWM_SUBACTIVE,
    PGWM_SLEEP,
    PGWM_SUBSLEEP,
    PGWM_WATCH,
    PGWM_STANDBY
  } pgwm_mode_e;
endpackage : pgwm_pkg

//--- logic/pgwm_pin_select.sv
// Per-pin function selection for the port
`timescale 1ns/1ps
module pgwm_pin_select
  import pgwm_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
)
(
  // Settings
  input wire logic [WIDTH-1:0] direction,
  input wire logic [WIDTH-1:0] outData,
  input wire logic [WIDTH-1:0] pullupEn,
  input wire logic [WIDTH-1:0] funcSel,
  input wire logic [pgwm_pkg::SEGMENT_FIELD_WIDTH-1:0] segmentField,
  // Decoded pin controls
  output logic [WIDTH-1:0] next_drive,
  output logic [WIDTH-1:0] next_level,
  output logic [WIDTH-1:0] next_pullup,
  output logic [WIDTH-1:0] next_wakeEn,
  output logic [WIDTH-1:0] next_segmentOwn
);
  import pgwm_pkg::*;

  always_comb
  begin
    for (int n = 0; n < WIDTH; n++)
    begin
      next_segmentOwn[n] = segmentField[SEGMENT_SELECT_BIT];
      next_wakeEn[n] = !next_segmentOwn[n] && funcSel[n];
      next_drive[n] = !next_segmentOwn[n] && !funcSel[n] && direction[n];
      next_level[n] = outData[n];
      next_pullup[n] = !next_segmentOwn[n] && !direction[n] && pullupEn[n];
    end
  end
endmodule : pgwm_pin_select

//--- tb/pgwm_pin_model.sv
// Pin-side model of the outside world around the eight-pin port
`timescale 1ns/1ps
module pgwm_pin_model
  import pgwm_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Port side
  input wire logic [pgwm_pkg::PORT_WIDTH-1:0] pinOut,
  input wire logic [pgwm_pkg::PORT_WIDTH-1:0] pinOeN,
  input wire logic [pgwm_pkg::PORT_WIDTH-1:0] pullOn,
  // Outside drivers
  input wire logic [pgwm_pkg::PORT_WIDTH-1:0] extVal,
  input wire logic [pgwm_pkg::PORT_WIDTH-1:0] extEn,
  output logic [pgwm_pkg::PORT_WIDTH-1:0] pinLevel
);
  logic [PORT_WIDTH-1:0] floatLvl = 8'h5a;
  // Lines left floating without pull-up wander every cycle
  always @(posedge clk_sys)
  begin
    floatLvl <= ~floatLvl;
  end
  assign pinLevel = (~pinOeN & pinOut) | (pinOeN & extEn & extVal)
    | (pinOeN & ~extEn & (pullOn | floatLvl));
endmodule : pgwm_pin_model

//--- tb/test_port5_gpio_wakeup_mux.sv
// Self-checking bench for the eight-pin port
`timescale 1ns/1ps
module test_port5_gpio_wakeup_mux;
  import pgwm_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pslverr, pready, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb, segmentField;
  pgwm_mode_e powerMode;
  logic [7:0] pinIn, pinOut, oeN, pullOn, wake, segmentEn, extVal, extEn, dir, dat, pu, fs;
  int n_mismatch, comparisons, seed;

  pgwm_port u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .powerMode(powerMode),
    .lcdSegmentSelectField(segmentField), .generalIoPinIn(pinIn), .generalIoPinOut(pinOut),
    .generalIoPinOeN(oeN), .pullupOn(pullOn), .wakeupRequestInput(wake),
    .lcdSegmentOutputEn(segmentEn));
  pgwm_pin_model u_pins (.clk_sys(clk_sys), .pinOut(pinOut), .pinOeN(oeN),
    .pullOn(pullOn), .extVal(extVal), .extEn(extEn), .pinLevel(pinIn));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] port_read(input logic [7:0] d, input logic [7:0] s,
    input logic [7:0] p);
    return (d & s) | (~d & p);
  endfunction : port_read

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {16'h0000, a};
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      $display("[FAIL] pready expected 1 seen %b", pready);
      stop_test();
    end
  endtask : apb

  task automatic settle;
    repeat (3) @(posedge clk_sys);
  endtask : settle

  initial
  begin
    seed = 16072;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    powerMode = PGWM_ACTIVE;
    segmentField = 4'h0;
    extVal = 8'h3c;
    extEn = 8'hff;
    repeat (5) @(posedge clk_sys);
    chk("oeN", 8'hff, oeN);
    rst <= 1'b0;
    apb(1'b0, ADDR_DIRECTION, 8'h00);
    chk("dirRead", DIRECTION_READ, rd[7:0]);
    apb(1'b0, ADDR_FUNC_SEL, 8'h00);
    chk("funcSel", RST_FUNC_SEL, rd[7:0]);
    apb(1'b0, ADDR_PULLUP, 8'h00);
    chk("pullup", RST_PULLUP, rd[7:0]);
    apb(1'b0, ADDR_OUT_DATA, 8'h00);
    chk("port", 8'h3c, rd[7:0]);
    chk("oeN", 8'hff, oeN);
    $display("test reset done");
    repeat (24)
    begin
      dir = 8'($random(seed));
      dat = 8'($random(seed));
      pu = 8'($random(seed));
      fs = 8'($random(seed) & $random(seed));
      extVal <= 8'($random(seed));
      extEn <= ~(~dir & pu);
      segmentField <= {1'b0, 3'($random(seed))};
      powerMode <= dat[0] ? PGWM_ACTIVE : PGWM_SUBACTIVE;
      apb(1'b1, ADDR_DIRECTION, dir);
      apb(1'b1, ADDR_OUT_DATA, dat);
      apb(1'b1, ADDR_PULLUP, pu);
      apb(1'b1, ADDR_FUNC_SEL, fs);
      settle();
      chk("oeN", ~(dir & ~fs), oeN);
      chk("pinOut", dat & dir & ~fs, pinOut & ~oeN);
      chk("pullOn", ~dir & pu, pullOn);
      chk("wake", fs, wake);
      chk("segment", 8'h00, segmentEn);
      apb(1'b0, ADDR_OUT_DATA, 8'h00);
      chk("port", port_read(dir, dat, extVal | ~extEn), rd[7:0]);
    end
    $display("test random done");
    extEn <= 8'hff;
    segmentField <= 4'h8 | 4'($random(seed));
    settle();
    chk("segment", 8'hff, segmentEn);
    chk("oeN", 8'hff, oeN);
    chk("wake", 8'h00, wake);
    segmentField <= 4'h0;
    pstrb <= 4'he;
    apb(1'b1, ADDR_FUNC_SEL, ~fs);
    pstrb <= 4'hf;
    apb(1'b0, ADDR_FUNC_SEL, 8'h00);
    chk("strobe", fs, rd[7:0]);
    apb(1'b0, 16'hffd0, 8'h00);
    chk("unmapped", 8'h01, {7'h00, err});
    $display("test segment and bus done");
    apb(1'b1, ADDR_FUNC_SEL, 8'h00);
    apb(1'b1, ADDR_DIRECTION, 8'hff);
    apb(1'b1, ADDR_OUT_DATA, 8'ha5);
    settle();
    powerMode <= PGWM_SLEEP;
    apb(1'b1, ADDR_OUT_DATA, 8'h5a);
    settle();
    chk("hold", 8'ha5, pinOut);
    powerMode <= PGWM_STANDBY;
    settle();
    chk("standby", 8'hff, oeN);
    powerMode <= PGWM_ACTIVE;
    settle();
    chk("resume", 8'h5a, pinOut);
    rst <= 1'b1;
    settle();
    rst <= 1'b0;
    apb(1'b0, ADDR_OUT_DATA, 8'h00);
    chk("reReset", extVal, rd[7:0]);
    apb(1'b0, ADDR_PULLUP, 8'h00);
    chk("rePullup", RST_PULLUP, rd[7:0]);
    $display("test power done");
    stop_test();
  end
endmodule : test_port5_gpio_wakeup_mux
